// *** core/pwm_pin_owner.v ***
`timescale 1ns/100ps
`include "pwm_own_consts.vh"
module pwm_pin_owner (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // register port
    input  wire [3:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    // configuration strap
    input  wire        reset_pin_ownership_cfg,
    // generator drive, one bit per pair
    input  wire [2:0]  gen_high,
    input  wire [2:0]  gen_low,
    // port (general-purpose) drive
    input  wire [2:0]  gpio_high_out,
    input  wire [2:0]  gpio_high_oe,
    input  wire [2:0]  gpio_low_out,
    input  wire [2:0]  gpio_low_oe,
    // fault pins, active low
    input  wire        fault_a_input_n,
    input  wire        fault_b_input_n,
    // power-stage pins
    output reg  [2:0]  pin_high_out,
    output reg  [2:0]  pin_high_oe,
    output reg  [2:0]  pin_low_out,
    output reg  [2:0]  pin_low_oe,
    output wire        fault_a_active,
    output wire        fault_b_active
);
    // ****************************************
    // state
    // ****************************************
    reg [15:0] out_ctrl_q;
    reg [15:0] fault_a_q;
    reg [15:0] fault_b_q;
    reg [1:0]  unl_q;
    reg        strap_done_q;
    reg [1:0]  flt_a_stk_q;
    reg [2:0]  high_oe_d;
    reg [2:0]  low_oe_d;
    reg [2:0]  high_out_d;
    reg [2:0]  low_out_d;
    reg [2:0]  low_gen_d;
    reg [15:0] rdata_d;
    wire [1:0] flt_sync;
    wire       prot_addr;
    wire       prot_wr;
    wire       fault_any;
    wire [2:0] high_en;
    wire [2:0] low_en;
    wire [2:0] pair_ind;

    pwm_sync2 #(.W(2)) u_flt_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({fault_b_input_n, fault_a_input_n}),
        .q       (flt_sync)
    );

    assign prot_addr = (addr == `OFS_OUT_CTRL) || (addr == `OFS_FAULT_A) ||
                       (addr == `OFS_FAULT_B);

    // a protected write lands only as the first write after the second key; idle or read cycles in between keep it open
    assign prot_wr = wr && (unl_q == `UNL_OPEN) && prot_addr;

    // ****************************************
    // unlock sequence
    // ****************************************
    // key then key then target
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unl_q <= `UNL_IDLE;
        end else if (wr) begin
            // any other write in between breaks the sequence
            case (unl_q)
                `UNL_IDLE: unl_q <= (addr == `OFS_KEY && wdata == `KEY_FIRST) ?
                                    `UNL_KEY1 : `UNL_IDLE;
                `UNL_KEY1: unl_q <= (addr == `OFS_KEY && wdata == `KEY_SECOND) ?
                                    `UNL_OPEN : `UNL_IDLE;
                `UNL_OPEN: unl_q <= (addr == `OFS_KEY && wdata == `KEY_FIRST) ?
                                    `UNL_KEY1 : `UNL_IDLE;
                default:   unl_q <= `UNL_IDLE;
            endcase
        end
    end

    // ****************************************
    // protected registers
    // ****************************************
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_ctrl_q   <= `OUT_CTRL_RST;
            fault_a_q    <= `FAULT_CTRL_RST;
            fault_b_q    <= `FAULT_CTRL_RST;
            strap_done_q <= 1'b0;
        end else begin
            if (!strap_done_q) begin
                strap_done_q <= 1'b1;
                if (!reset_pin_ownership_cfg)
                    out_ctrl_q <= `OUT_CTRL_OWNED & `OUT_CTRL_MASK;
            end else if (prot_wr) begin
                case (addr)
                    `OFS_OUT_CTRL: out_ctrl_q <= wdata & `OUT_CTRL_MASK;
                    `OFS_FAULT_A:  fault_a_q  <= wdata & `FAULT_CTRL_MASK;
                    `OFS_FAULT_B:  fault_b_q  <= wdata & `FAULT_CTRL_MASK;
                    default:       out_ctrl_q <= out_ctrl_q;
                endcase
            end
        end
    end

    // ****************************************
    // fault flags
    // ****************************************
    // latched fault clears only with pin high and unlocked rewrite
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flt_a_stk_q <= 2'b00;
        end else begin
            if (fault_a_q[0] && !flt_sync[0])
                flt_a_stk_q[0] <= 1'b1;
            else if (prot_wr && addr == `OFS_FAULT_A && flt_sync[0])
                flt_a_stk_q[0] <= 1'b0;
            if (fault_b_q[0] && !flt_sync[1])
                flt_a_stk_q[1] <= 1'b1;
            else if (prot_wr && addr == `OFS_FAULT_B && flt_sync[1])
                flt_a_stk_q[1] <= 1'b0;
        end
    end
    assign fault_a_active = flt_a_stk_q[0];
    assign fault_b_active = flt_a_stk_q[1];

    // ****************************************
    // pin steering
    // ****************************************
    assign low_en    = out_ctrl_q[`POS_LOW_EN +: 3];
    assign high_en   = out_ctrl_q[`POS_HIGH_EN +: 3];
    assign pair_ind  = out_ctrl_q[`POS_PAIR_MODE +: 3];
    // either latched fault parks every generator-owned pin low
    assign fault_any = fault_a_active | fault_b_active;

    always @* begin : steer
        integer i;
        i          = 0;
        high_oe_d  = 3'b000;
        low_oe_d   = 3'b000;
        high_out_d = 3'b000;
        low_out_d  = 3'b000;
        low_gen_d  = 3'b000;
        for (i = 0; i < 3; i = i + 1) begin
            high_oe_d[i]  = high_en[i] ? 1'b1 : gpio_high_oe[i];
            low_oe_d[i]   = low_en[i] ? 1'b1 : gpio_low_oe[i];
            high_out_d[i] = high_en[i] ? (gen_high[i] & ~fault_any) : gpio_high_out[i];
            low_gen_d[i]  = pair_ind[i] ? gen_low[i] : ~gen_high[i];
            low_out_d[i]  = low_en[i] ? (low_gen_d[i] & ~fault_any) : gpio_low_out[i];
        end
    end

    // registered so the steering mux cannot glitch the power stage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_high_out <= 3'b000;
            pin_high_oe  <= 3'b000;
            pin_low_out  <= 3'b000;
            pin_low_oe   <= 3'b000;
        end else begin
            pin_high_out <= high_out_d;
            pin_high_oe  <= high_oe_d;
            pin_low_out  <= low_out_d;
            pin_low_oe   <= low_oe_d;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // data stands for one cycle only, so a stale read is never taken twice
    always @* begin
        rdata_d = 16'h0000;
        if (rd) begin
            case (addr)
                `OFS_OUT_CTRL:   rdata_d = out_ctrl_q & `OUT_CTRL_MASK;
                `OFS_FAULT_A:    rdata_d = fault_a_q;
                `OFS_FAULT_B:    rdata_d = fault_b_q;
                `OFS_PIN_STATUS: rdata_d = {10'h000, unl_q, flt_sync,
                                            fault_b_active, fault_a_active};
                default:         rdata_d = 16'h0000;
            endcase
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rdata_d;
        end
    end
endmodule

// *** core/pwm_sync2.v ***
`timescale 1ns/100ps
module pwm_sync2 #(
    parameter W = 2
) (
    // clock and reset
    input  wire         clk,
    input  wire         sys_rst,
    // data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule

// *** pkg/pwm_own_consts.vh ***
`ifndef PWM_OWN_CONSTS_VH
`define PWM_OWN_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_OUT_CTRL    4'h0
`define OFS_KEY         4'h1
`define OFS_FAULT_A     4'h2
`define OFS_FAULT_B     4'h3
`define OFS_PIN_STATUS  4'h4

// ****************************************
// keys and field layout
// ****************************************
`define KEY_FIRST       16'hABCD
`define KEY_SECOND      16'h4321
`define OUT_CTRL_MASK   16'h0777
`define FAULT_CTRL_MASK 16'h0001
`define POS_LOW_EN      0
`define POS_HIGH_EN     4
`define POS_PAIR_MODE   8
`define OUT_CTRL_RST    16'h0000
`define OUT_CTRL_OWNED  16'h0077
`define FAULT_CTRL_RST  16'h0000

// ****************************************
// unlock states
// ****************************************
`define UNL_IDLE        2'b00
`define UNL_KEY1        2'b01
`define UNL_OPEN        2'b10

`endif

// *** testbench/power_stage_model.sv ***
`timescale 1ns/100ps
module power_stage_model (
    // bench side
    input wire       clk,
    input wire [1:0] trip,
    // fault lines
    output logic     fault_a_input_n,
    output logic     fault_b_input_n
);
    initial {fault_b_input_n, fault_a_input_n} = 2'b11;
    always @(posedge clk) {fault_b_input_n, fault_a_input_n} <= ~trip;
endmodule

// *** testbench/pwm_pin_owner_monitor.sv ***
`timescale 1ns/100ps
`include "pwm_own_consts.vh"
module pwm_pin_owner_monitor (
    // clock, reset and strap
    input wire        clk,
    input wire        sys_rst,
    input wire        reset_pin_ownership_cfg,
    // bus and pins
    input wire [3:0]  addr,
    input wire [15:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [15:0] rdata,
    input wire [2:0]  gpio_high_oe,
    input wire [2:0]  pin_high_oe,
    input wire [2:0]  pin_low_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****
    // keys and pin ownership
    // ****
    sequence s_k1; wr && addr == `OFS_KEY && wdata == `KEY_FIRST; endsequence
    sequence s_k2; wr && addr == `OFS_KEY && wdata == `KEY_SECOND; endsequence
    sequence s_st; rd && addr == `OFS_PIN_STATUS; endsequence
    property p_open; s_k1 ##1 s_k2 ##1 s_st |=> rdata[5:4] == `UNL_OPEN; endproperty
    a_open: assert property (p_open) else $error("keys left it shut");
    property p_shut; wr && addr == `OFS_OUT_CTRL ##1 s_st |=> rdata[5:4] == `UNL_IDLE; endproperty
    a_shut: assert property (p_shut) else $error("still open");
    property p_mask; rd && addr == `OFS_OUT_CTRL |=> (rdata & 16'hF888) == 16'h0000; endproperty
    a_mask: assert property (p_mask) else $error("spare bits set");
    // pins settle two edges after release: strap, then drive
    property p_cfg0; $fell(sys_rst) && !reset_pin_ownership_cfg |-> ##2 (pin_high_oe & pin_low_oe) == 3'h7; endproperty
    a_cfg0: assert property (p_cfg0) else $error("pins not owned");
    property p_cfg1; $fell(sys_rst) && reset_pin_ownership_cfg |-> ##2 pin_high_oe == $past(gpio_high_oe); endproperty
    a_cfg1: assert property (p_cfg1) else $error("pins not released");
    property p_oe; !$past(sys_rst) |-> (~pin_high_oe & $past(gpio_high_oe)) == 3'h0; endproperty
    a_oe: assert property (p_oe) else $error("port enable lost");
endmodule
bind pwm_pin_owner pwm_pin_owner_monitor mon_u (.*);

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
`include "pwm_own_consts.vh"
module tb_top;
    logic        clk = 0, sys_rst = 1, wr = 0, rd = 0, reset_pin_ownership_cfg = 0;
    logic [3:0]  addr = 0;
    logic [15:0] wdata = 0, rdata, ctl;
    logic [2:0]  gen_high = 0, gen_low = 0, gpio_high_out = 0, gpio_high_oe = 0;
    logic [2:0]  gpio_low_out = 0, gpio_low_oe = 0, pin_high_out, pin_high_oe;
    logic [2:0]  pin_low_out, pin_low_oe;
    logic [1:0]  trip = 0;
    logic        fault_a_input_n, fault_b_input_n, fault_a_active, fault_b_active;
    logic [31:0] r;
    integer      error_cnt = 0, check_count = 0, seed = 60, i;
    always #10 clk = ~clk;
    pwm_pin_owner dut_u (.*);
    power_stage_model ps_u (.*);
    // ****
    // bus, expectations, checks
    // ****
    task chk(input [15:0] v, e);
        check_count++;
        if (v !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, v, e);
        end
    endtask
    task bus(input w, c, input [3:0] a, input [15:0] d);
        wr <= w;
        rd <= c;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    // read data stands one cycle: look at it mid-cycle, drive again on the edge
    task rdc(input [3:0] a, input [15:0] e);
        bus(0, 1, a, 0);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask
    task ulk(input [3:0] a, input [15:0] d);
        bus(1, 0, `OFS_KEY, `KEY_FIRST);
        bus(1, 0, `OFS_KEY, `KEY_SECOND);
        bus(1, 0, a, d);
        bus(0, 0, 0, 0);
    endtask
    task rst(input c);
        sys_rst <= 1;
        reset_pin_ownership_cfg <= c;
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        repeat (3) @(posedge clk);
    endtask
    // complementary low side follows the inverted high drive
    function automatic logic [11:0] exp_pins(input [15:0] c, input f);
        logic [2:0] h, l, g;
        h = c[6:4];
        l = c[2:0];
        g = (c[10:8] & gen_low) | (~c[10:8] & ~gen_high);
        exp_pins = {h | gpio_high_oe, (h & gen_high & {3{~f}}) | (~h & gpio_high_out),
                    l | gpio_low_oe, (l & g & {3{~f}}) | (~l & gpio_low_out)};
    endfunction
    task pchk(input [15:0] c, input f);
        @(negedge clk);
        chk({pin_high_oe, pin_high_out, pin_low_oe, pin_low_out}, exp_pins(c, f));
        @(posedge clk);
    endtask
    task fchk(input [1:0] e);
        @(negedge clk);
        chk({fault_b_active, fault_a_active}, e);
        @(posedge clk);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rst(0);
        rdc(`OFS_OUT_CTRL, 16'h0077);
        pchk(16'h0077, 0);
        bus(1, 0, `OFS_KEY, `KEY_FIRST);
        bus(1, 0, `OFS_OUT_CTRL, 0);
        bus(1, 0, `OFS_KEY, `KEY_SECOND);
        bus(1, 0, `OFS_OUT_CTRL, 0);
        rdc(`OFS_OUT_CTRL, 16'h0077);
        bus(1, 0, `OFS_KEY, `KEY_FIRST);
        bus(1, 0, `OFS_KEY, `KEY_SECOND);
        rdc(`OFS_PIN_STATUS, 16'h002C);
        bus(1, 0, `OFS_OUT_CTRL, 16'h0070);
        rdc(`OFS_PIN_STATUS, 16'h000C);
        rdc(`OFS_OUT_CTRL, 16'h0070);
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            {gen_high, gen_low, gpio_high_out,
             gpio_high_oe, gpio_low_out, gpio_low_oe} <= r[31:14];
            ctl = i ? r[15:0] : 16'hFFFF;
            ulk(`OFS_OUT_CTRL, ctl);
            rdc(`OFS_OUT_CTRL, ctl & `OUT_CTRL_MASK);
            pchk(ctl & `OUT_CTRL_MASK, 0);
        end
        // every pin owned and every high-side pin driven high, so a forced-low pin is visible
        gen_high <= 3'b111;
        ctl = 16'h0077;
        ulk(`OFS_OUT_CTRL, ctl);
        for (i = 0; i < 2; i++) begin
            ulk(4'(2 + i), 16'h0001);
            trip <= 2'(1 << i);
            repeat (8) @(posedge clk);
            fchk(2'(1 << i));
            pchk(ctl, 1);
            // a rewrite while the line is still low leaves the fault latched
            ulk(4'(2 + i), 0);
            fchk(2'(1 << i));
            trip <= 0;
            repeat (4) @(posedge clk);
            ulk(4'(2 + i), 0);
            fchk(0);
        end
        rst(1);
        rdc(`OFS_OUT_CTRL, 0);
        pchk(0, 0);
        finish_test;
    end
    initial begin
        #50000;
        error_cnt++;
        finish_test;
    end
endmodule
